// *** design/cmbid_defs.svh ***
/*
 identifier-word constants for the message buffers kept in data ram:
 field positions, masks and the buffer-area geometry defaults.
 assumes it is included by the package and the design modules only.
*/
`ifndef CMBID_DEFS_SVH
`define CMBID_DEFS_SVH

// ==========================================================================
// word 0 layout
`define CMBID_W0_IDE_BIT     0
`define CMBID_W0_SRR_BIT     1
`define CMBID_W0_SID_LSB     2
`define CMBID_W0_SID_MSB     12
`define CMBID_W0_USED_MASK   16'h1fff

// ==========================================================================
// word 1 layout
`define CMBID_W1_EID_LSB     0
`define CMBID_W1_EID_MSB     11
`define CMBID_W1_USED_MASK   16'h0fff

// ==========================================================================
// buffer area defaults (software reprograms base and size)
`define CMBID_RAM_WORDS      1024
`define CMBID_ADDR_W         10
`define CMBID_WORDS_PER_BUF  8
`define CMBID_BASE_RST       10'h000
`define CMBID_SIZE_RST       10'h000

`endif

// *** design/cmbid_pkg.sv ***
/*
 types shared by the identifier-word logic of the message buffers.
 assumes cmbid_defs.svh is on the include path.
*/
`include "cmbid_defs.svh"

package cmbid_pkg;

  // ========================================================================
  // decoded identifier words
  typedef struct packed {
    logic [10:0] std_identifier_field;
    logic        srr;
    logic        ide;
  } cmbid_word0_t;

  typedef struct packed {
    logic [11:0] ext_identifier_upper_field;
  } cmbid_word1_t;

  typedef struct packed {
    logic        valid;
    logic [9:0]  buf_index;
    cmbid_word0_t w0;
    cmbid_word1_t w1;
  } cmbid_frame_id_t;

  typedef enum logic [1:0] {
    CMBID_ID_STD_DATA,
    CMBID_ID_STD_REMOTE,
    CMBID_ID_EXT,
    CMBID_ID_EXT_BAD_SRR
  } cmbid_kind_t;

endpackage : cmbid_pkg

// *** design/cmbid_ram.sv ***
/*
 plain single-port data ram with write mask, holding the buffer area.
 assumes one clock; contents are not reset.
*/
`include "cmbid_defs.svh"

module cmbid_ram #(
  parameter int WORDS  = `CMBID_RAM_WORDS,
  parameter int ADDR_W = `CMBID_ADDR_W
) (
  // clock
  input  wire logic              i_sys_clk,
  // access
  input  wire logic              i_en,
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [15:0]       i_wmask,
  input  wire logic [15:0]       i_wdata,
  output logic      [15:0]       o_rdata
);

  logic [15:0] mem [WORDS];

  // ==========================================================================
  // no reset on the array: contents stay undefined until written
  always_ff @(posedge i_sys_clk) begin
    if (i_en && i_we) begin
      mem[i_addr] <= (mem[i_addr] & ~i_wmask) | (i_wdata & i_wmask);
    end
    if (i_en) begin
      o_rdata <= mem[i_addr];
    end
  end

endmodule : cmbid_ram

// *** design/cmbid_top.sv ***
/*
 identifier words of the can message buffers, held in ordinary data ram.
 a cpu port and a controller port share one ram; the controller side
 writes received ids and fetches ids of frames to transmit, confined to
 the buffer area set by base and size inputs.
 assumes the cpu and controller requests are synchronous to i_sys_clk.
*/
// Function
// RULE_01: buffers live in ordinary data ram
// RULE_02: no register decode for buffer contents
// RULE_03: software writes outgoing buffers into ram
// RULE_04: controller uses only configured base and size
// RULE_05: srr means remote request; extended needs srr
// RULE_06: ide bit selects extended or standard id
// RULE_07: word 1 bits 11:0 hold ext_identifier_upper_field
// RULE_08: word 1 bits 15:12 read zero
// RULE_09: word 0 bits 12:2 sid, 15:13 zero
// RULE_10: identifier words undefined after reset
`include "cmbid_defs.svh"

module cmbid_top
  import cmbid_pkg::*;
#(
  parameter int ADDR_W = `CMBID_ADDR_W
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  // buffer area set by software
  input  wire logic [ADDR_W-1:0] i_area_base,
  input  wire logic [ADDR_W-1:0] i_area_words,
  // cpu data-ram port
  input  wire logic              i_cpu_req,
  input  wire logic              i_cpu_we,
  input  wire logic [ADDR_W-1:0] i_cpu_addr,
  input  wire logic [15:0]       i_cpu_wdata,
  output logic      [15:0]       o_cpu_rdata,
  output logic                   o_cpu_ack,
  // controller: fetch id of a buffer to transmit
  input  wire logic              i_tx_req,
  input  wire logic [ADDR_W-1:0] i_tx_buf,
  output cmbid_frame_id_t        o_tx_id,
  output cmbid_kind_t            o_tx_kind,
  // controller: store id of a received frame
  input  wire logic              i_rx_req,
  input  wire logic [ADDR_W-1:0] i_rx_buf,
  input  wire cmbid_word0_t      i_rx_w0,
  input  wire cmbid_word1_t      i_rx_w1,
  output logic                   o_rx_done,
  // controller request outside the area; sequencer busy
  output logic                   o_area_err,
  output logic                   o_busy
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CPU,
    ST_TX0,
    ST_TX1,
    ST_TX_WAIT,
    ST_RX1
  } cmbid_state_t;

  cmbid_state_t    state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [ADDR_W-1:0] bufidx_r, bufidx_nxt;
  cmbid_frame_id_t tx_id_r, tx_id_nxt;
  cmbid_kind_t     kind_r, kind_nxt;
  cmbid_word1_t    rx_w1_r, rx_w1_nxt;
  logic            cpu_ack_r, cpu_ack_nxt;
  logic            rx_done_r, rx_done_nxt;
  logic            err_r, err_nxt;
  logic [15:0]     cpu_rdata_r, cpu_rdata_nxt;
  logic            cpu_rd_r, cpu_rd_nxt;

  logic              ram_en;
  logic              ram_we;
  logic [ADDR_W-1:0] ram_addr;
  logic [15:0]       ram_wmask;
  logic [15:0]       ram_wdata;
  logic [15:0]       ram_rdata;
  logic [ADDR_W-1:0] cpu_off;
  logic [ADDR_W-1:0] cpu_slot;

  // ==========================================================================
  // area check: start of buffer plus its two id words must fit the area
  function automatic logic in_area(input logic [ADDR_W-1:0] idx);
    logic [ADDR_W+3:0] off;
    logic [ADDR_W+3:0] lim;
    off = (ADDR_W+4)'(idx) * (ADDR_W+4)'(`CMBID_WORDS_PER_BUF);
    lim = (ADDR_W+4)'(i_area_words);
    in_area = (off + (ADDR_W+4)'(2)) <= lim; // RULE_04
  endfunction : in_area

  function automatic logic [ADDR_W-1:0] buf_addr(input logic [ADDR_W-1:0] idx);
    buf_addr = i_area_base + ADDR_W'(idx * ADDR_W'(`CMBID_WORDS_PER_BUF)); // RULE_04
  endfunction : buf_addr

  // cpu word position relative to the area, used to spot id words
  assign cpu_off  = i_cpu_addr - i_area_base;
  assign cpu_slot = cpu_off % ADDR_W'(`CMBID_WORDS_PER_BUF);

  // ==========================================================================
  // the ram: same store for cpu and controller, no register decode
  cmbid_ram #(
    .WORDS  (1 << ADDR_W),
    .ADDR_W (ADDR_W)
  ) u_ram (                                                      // RULE_01
    .i_sys_clk (i_sys_clk),
    .i_en      (ram_en),
    .i_we      (ram_we),
    .i_addr    (ram_addr),
    .i_wmask   (ram_wmask),
    .i_wdata   (ram_wdata),
    .o_rdata   (ram_rdata)
  );

  // ==========================================================================
  // sequencer: cpu wins idle cycles; one ram access per cycle
  always_comb begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    bufidx_nxt    = bufidx_r;
    tx_id_nxt     = tx_id_r;
    tx_id_nxt.valid = 1'b0;
    kind_nxt      = kind_r;
    rx_w1_nxt     = rx_w1_r;
    cpu_ack_nxt   = 1'b0;
    rx_done_nxt   = 1'b0;
    err_nxt       = 1'b0;
    cpu_rdata_nxt = cpu_rdata_r;
    cpu_rd_nxt    = 1'b0;
    ram_en        = 1'b0;
    ram_we        = 1'b0;
    ram_addr      = addr_r;
    ram_wmask     = 16'hffff;
    ram_wdata     = 16'h0000;
    unique case (state_r)
      ST_IDLE: begin
        if (i_cpu_req) begin
          // raw word access: software fills buffers directly
          ram_en     = 1'b1;                                     // RULE_03
          ram_we     = i_cpu_we;
          ram_addr   = i_cpu_addr;                               // RULE_02
          ram_wdata  = i_cpu_wdata;
          // id words inside the area keep their unused bits at zero
          if (in_area(cpu_off / ADDR_W'(`CMBID_WORDS_PER_BUF))) begin
            if (cpu_slot == ADDR_W'(0)) begin
              ram_wdata = i_cpu_wdata & `CMBID_W0_USED_MASK;     // RULE_09
            end else if (cpu_slot == ADDR_W'(1)) begin
              ram_wdata = i_cpu_wdata & `CMBID_W1_USED_MASK;     // RULE_08
            end
          end
          cpu_rd_nxt = !i_cpu_we;
          state_nxt  = ST_CPU;
        end else if (i_tx_req) begin
          if (in_area(i_tx_buf)) begin
            ram_en     = 1'b1;
            ram_addr   = buf_addr(i_tx_buf);
            addr_nxt   = buf_addr(i_tx_buf) + ADDR_W'(1);
            bufidx_nxt = i_tx_buf;
            state_nxt  = ST_TX0;
          end else begin
            err_nxt = 1'b1;                                      // RULE_04
          end
        end else if (i_rx_req) begin
          if (in_area(i_rx_buf)) begin
            // word 0 written whole; unused bits stored as zero
            ram_en    = 1'b1;
            ram_we    = 1'b1;
            ram_addr  = buf_addr(i_rx_buf);
            ram_wdata = {3'h0, i_rx_w0.std_identifier_field,
                         i_rx_w0.srr, i_rx_w0.ide};              // RULE_09
            addr_nxt  = buf_addr(i_rx_buf) + ADDR_W'(1);
            rx_w1_nxt = i_rx_w1;
            state_nxt = ST_RX1;
          end else begin
            err_nxt = 1'b1;                                      // RULE_04
          end
        end
      end
      ST_CPU: begin
        cpu_ack_nxt = 1'b1;
        state_nxt   = ST_IDLE;
      end
      ST_TX0: begin
        // word 0 data now on ram_rdata; start word 1 read
        tx_id_nxt.w0.std_identifier_field =
          ram_rdata[`CMBID_W0_SID_MSB:`CMBID_W0_SID_LSB];        // RULE_09
        tx_id_nxt.w0.srr = ram_rdata[`CMBID_W0_SRR_BIT];
        tx_id_nxt.w0.ide = ram_rdata[`CMBID_W0_IDE_BIT];         // RULE_06
        ram_en    = 1'b1;
        ram_addr  = addr_r;
        state_nxt = ST_TX1;
      end
      ST_TX1: begin
        tx_id_nxt.w1.ext_identifier_upper_field =
          ram_rdata[`CMBID_W1_EID_MSB:`CMBID_W1_EID_LSB];        // RULE_07
        tx_id_nxt.buf_index = bufidx_r;
        tx_id_nxt.valid     = 1'b1;
        // extended frames carry srr=1; a 0 there is flagged, not fixed
        if (tx_id_r.w0.ide) begin                                // RULE_06
          kind_nxt = tx_id_r.w0.srr ? CMBID_ID_EXT : CMBID_ID_EXT_BAD_SRR; // RULE_05
        end else begin
          kind_nxt = tx_id_r.w0.srr ? CMBID_ID_STD_REMOTE : CMBID_ID_STD_DATA; // RULE_05
        end
        state_nxt = ST_TX_WAIT;
      end
      ST_TX_WAIT: begin
        state_nxt = ST_IDLE;
      end
      ST_RX1: begin
        ram_en    = 1'b1;
        ram_we    = 1'b1;
        ram_addr  = addr_r;
        ram_wdata = {4'h0, rx_w1_r.ext_identifier_upper_field};  // RULE_08
        rx_done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
    if (cpu_rd_r) begin
      cpu_rdata_nxt = ram_rdata;
    end
  end

  // ==========================================================================
  // control state only; stored id words are not reset
  always_ff @(posedge i_sys_clk) begin                           // RULE_10
    if (!i_reset_n) begin
      state_r     <= ST_IDLE;
      addr_r      <= ADDR_W'(`CMBID_BASE_RST);
      bufidx_r    <= '0;
      tx_id_r     <= '0;
      kind_r      <= CMBID_ID_STD_DATA;
      rx_w1_r     <= '0;
      cpu_ack_r   <= 1'b0;
      rx_done_r   <= 1'b0;
      err_r       <= 1'b0;
      cpu_rdata_r <= 16'h0000;
      cpu_rd_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      bufidx_r    <= bufidx_nxt;
      tx_id_r     <= tx_id_nxt;
      kind_r      <= kind_nxt;
      rx_w1_r     <= rx_w1_nxt;
      cpu_ack_r   <= cpu_ack_nxt;
      rx_done_r   <= rx_done_nxt;
      err_r       <= err_nxt;
      cpu_rdata_r <= cpu_rdata_nxt;
      cpu_rd_r    <= cpu_rd_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign o_cpu_rdata = cpu_rdata_r;
  assign o_cpu_ack   = cpu_ack_r;
  assign o_tx_id     = tx_id_r;
  assign o_tx_kind   = kind_r;
  assign o_rx_done   = rx_done_r;
  assign o_area_err  = err_r;
  assign o_busy      = (state_r != ST_IDLE);

endmodule : cmbid_top

// *** bench/cmbid_top_asserts.sv ***
/*
 port checker of cmbid_top.
 assumes one clock and a synchronous active-low reset.
*/
// ========
// checker
module cmbid_top_asserts
  import cmbid_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic              i_sys_clk,
  input wire logic              i_reset_n,
  // watched ports
  input wire logic [ADDR_W-1:0] i_area_words,
  input wire logic              i_cpu_req,
  input wire logic              i_tx_req,
  input wire logic [ADDR_W-1:0] i_tx_buf,
  input wire logic              i_rx_req,
  input wire logic [ADDR_W-1:0] i_rx_buf,
  input wire logic [15:0]       o_cpu_rdata,
  input wire logic              o_cpu_ack,
  input wire cmbid_frame_id_t   o_tx_id,
  input wire cmbid_kind_t       o_tx_kind,
  input wire logic              o_rx_done,
  input wire logic              o_area_err,
  input wire logic              o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx_t, rx_t, tx_in, rx_in;
  assign tx_t  = i_tx_req && !i_cpu_req && !o_busy;
  assign rx_t  = i_rx_req && !i_tx_req && !i_cpu_req && !o_busy;
  assign tx_in = (int'(i_tx_buf) * 8 + 2) <= int'(i_area_words);
  assign rx_in = (int'(i_rx_buf) * 8 + 2) <= int'(i_area_words);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  AST_CPU_ACK: assert property (i_cpu_req && !o_busy |-> ##2 o_cpu_ack)
    else $error("cpu ack late");
  AST_RDATA_HOLD: assert property ($changed(o_cpu_rdata) |-> o_cpu_ack)
    else $error("read data moved without ack");
  AST_TX_FETCH: assert property (tx_t && tx_in |-> ##3 o_tx_id.valid)
    else $error("tx id late");
  AST_TX_BUSY: assert property (tx_t && tx_in |=> o_busy [*2])
    else $error("busy dropped in fetch");
  AST_AREA_ERR: assert property ((tx_t && !tx_in) || (rx_t && !rx_in) |=> o_area_err)
    else $error("area error missing");
  AST_ERR_NOFETCH: assert property (tx_t && !tx_in |=> !o_tx_id.valid [*4])
    else $error("fetch outside area");
  AST_RX_DONE: assert property (rx_t && rx_in |-> ##2 (o_rx_done && !o_area_err))
    else $error("rx done late");
  AST_KIND: assert property (o_tx_id.valid |-> o_tx_kind == (o_tx_id.w0.ide ?
    (o_tx_id.w0.srr ? CMBID_ID_EXT : CMBID_ID_EXT_BAD_SRR) :
    (o_tx_id.w0.srr ? CMBID_ID_STD_REMOTE : CMBID_ID_STD_DATA))) else $error("bad kind");
  AST_ID_HOLD: assert property ($changed(o_tx_id.w1) |-> o_tx_id.valid)
    else $error("id field moved without valid");
endmodule : cmbid_top_asserts

bind cmbid_top cmbid_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_area_words(i_area_words),
  .i_cpu_req(i_cpu_req), .i_tx_req(i_tx_req), .i_tx_buf(i_tx_buf), .i_rx_req(i_rx_req),
  .i_rx_buf(i_rx_buf), .o_cpu_rdata(o_cpu_rdata), .o_cpu_ack(o_cpu_ack), .o_tx_id(o_tx_id),
  .o_tx_kind(o_tx_kind), .o_rx_done(o_rx_done), .o_area_err(o_area_err), .o_busy(o_busy));

// *** bench/cmbid_node_model.sv ***
/*
 can-node model: one received identifier per go pulse.
 assumes the bench keeps cpu and tx requests quiet meanwhile.
*/
module cmbid_node_model
  import cmbid_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // frame to deliver
  input  wire logic        i_go,
  input  wire logic [9:0]  i_buf,
  input  wire logic [10:0] i_sid,
  input  wire logic        i_ext,
  input  wire logic [11:0] i_eid,
  // receive port
  input  wire logic        i_busy,
  output logic             o_rx_req,
  output logic [9:0]       o_rx_buf,
  output cmbid_word0_t     o_rx_w0,
  output cmbid_word1_t     o_rx_w1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_rx_req, o_rx_buf, o_rx_w0, o_rx_w1} = '0;
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rx_req <= 1'b0;
    end else if (i_go && !o_rx_req) begin
      o_rx_req <= 1'b1;
      o_rx_buf <= i_buf;
      o_rx_w0  <= '{i_sid, i_ext, i_ext};
      o_rx_w1  <= i_eid;
    end else if (o_rx_req && !i_busy) begin
      // released fields flip so stale values never pass for fresh ones
      o_rx_req <= 1'b0;
      o_rx_buf <= ~o_rx_buf;
      o_rx_w0  <= ~o_rx_w0;
      o_rx_w1  <= ~o_rx_w1;
    end
  end
endmodule : cmbid_node_model

// *** bench/tb_top.sv ***
/*
 self-checking bench of cmbid_top: id table, rx store, area limits.
 assumes design, package and checker compiled before it.
*/
module tb_top
  import cmbid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [15:0] w0; logic [15:0] w1; cmbid_kind_t k;} cmbid_tbrow_t;
  // area ends exactly at word 1 of buffer 3
  localparam logic [9:0]   BASE = 10'h040;
  localparam logic [9:0]   AREA = 10'h01a;
  localparam cmbid_tbrow_t ROWS [4] = '{'{16'hfffc, 16'h0abc, CMBID_ID_STD_DATA},
    '{16'h0ab6, 16'hf555, CMBID_ID_STD_REMOTE}, '{16'h0003, 16'hffff, CMBID_ID_EXT},
    '{16'h1555, 16'h0123, CMBID_ID_EXT_BAD_SRR}};
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, creq = 1'b0, cwe = 1'b0, treq = 1'b0, go = 1'b0;
  logic [9:0]      caddr = '0, tbuf = '0, rbuf_c = '0, rbuf;
  logic [15:0]     cwd = '0, crd, q;
  logic [10:0]     sid_c = '0;
  logic            ext_c = 1'b0, cack, rreq, rdone, aerr, busy;
  logic [11:0]     eid_c = '0;
  cmbid_frame_id_t tid;
  cmbid_kind_t     kind;
  cmbid_word0_t    rw0;
  cmbid_word1_t    rw1;
  int              n_mismatch = 0;
  int              checks = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  cmbid_top DUT (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_area_base(BASE),
    .i_area_words(AREA), .i_cpu_req(creq), .i_cpu_we(cwe), .i_cpu_addr(caddr),
    .i_cpu_wdata(cwd), .o_cpu_rdata(crd), .o_cpu_ack(cack), .i_tx_req(treq), .i_tx_buf(tbuf),
    .o_tx_id(tid), .o_tx_kind(kind), .i_rx_req(rreq), .i_rx_buf(rbuf), .i_rx_w0(rw0),
    .i_rx_w1(rw1), .o_rx_done(rdone), .o_area_err(aerr), .o_busy(busy));
  cmbid_node_model u_node (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_go(go),
    .i_buf(rbuf_c), .i_sid(sid_c), .i_ext(ext_c), .i_eid(eid_c), .i_busy(busy),
    .o_rx_req(rreq), .o_rx_buf(rbuf), .o_rx_w0(rw0), .o_rx_w1(rw1));
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic idle;
    int k;
    @(negedge i_sys_clk);
    for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge i_sys_clk);
    if (busy !== 1'b0) begin chk(1, 0); stop_test(); end
  endtask : idle
  // a done pulse may already stand at the release edge, so look before waiting
  task automatic wait_done;
    int k;
    for (k = 0; k < 8; k++) begin
      if ((cack | tid.valid | rdone | aerr) === 1'b1) break;
      @(posedge i_sys_clk);
      #1;
    end
    if (k == 8) begin chk(1, 0); stop_test(); end
  endtask : wait_done
  task automatic cpu(input logic we, input logic [9:0] a, input logic [15:0] d);
    idle();
    {creq, cwe, caddr, cwd} = {1'b1, we, a, d};
    @(negedge i_sys_clk);
    {creq, caddr, cwd} = {1'b0, ~a, ~d};
    wait_done();
    chk(cack, 1'b1);
    q = crd;
  endtask : cpu
  task automatic tx(input logic [9:0] b);
    idle();
    {treq, tbuf} = {1'b1, b};
    @(negedge i_sys_clk);
    {treq, tbuf} = {1'b0, ~b};
    wait_done();
  endtask : tx
  task automatic rx(input logic [9:0] b, input logic [10:0] s, input logic e);
    idle();
    {go, rbuf_c, sid_c, ext_c, eid_c} = {1'b1, b, s, e, 12'hc3f};
    @(negedge i_sys_clk);
    go = 1'b0;
    wait_done();
  endtask : rx
  initial begin
    repeat (5) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    chk(tid, 0);
    for (int i = 0; i < 4; i++) begin
      cpu(1'b1, BASE + 10'(8 * i), ROWS[i].w0);
      cpu(1'b1, BASE + 10'(8 * i + 1), ROWS[i].w1);
      tx(10'(i));
      chk(tid, {1'b1, 10'(i), ROWS[i].w0[12:0], ROWS[i].w1[11:0]});
      chk(kind, ROWS[i].k);
    end
    cpu(1'b1, BASE + 10'h10, 16'hffff);
    cpu(1'b1, BASE + 10'h11, 16'hffff);
    rx(10'h2, 11'h5a5, 1'b1);
    chk({rdone, aerr}, 2'b10);
    cpu(1'b0, BASE + 10'h10, 16'h0000);
    chk(q, 16'h1697);
    cpu(1'b0, BASE + 10'h11, 16'h0000);
    chk(q, 16'h0c3f);
    cpu(1'b1, BASE + 10'h18, 16'hffff);
    cpu(1'b0, BASE + 10'h18, 16'h0000);
    chk(q, 16'h1fff);
    cpu(1'b1, BASE + 10'h19, 16'hffff);
    cpu(1'b0, BASE + 10'h19, 16'h0000);
    chk(q, 16'h0fff);
    tx(10'h4);
    chk({aerr, tid.valid}, 2'b10);
    cpu(1'b1, BASE + 10'h28, 16'h1234);
    rx(10'h5, 11'h000, 1'b0);
    chk(aerr, 1'b1);
    cpu(1'b0, BASE + 10'h28, 16'h0000);
    chk(q, 16'h1234);
    cpu(1'b1, 10'h3ff, 16'hbeef);
    cpu(1'b0, 10'h3ff, 16'h0000);
    chk(q, 16'hbeef);
    @(negedge i_sys_clk);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    chk({tid, crd}, 0);
    stop_test();
  end
endmodule : tb_top
